/* core/cgsmb_ctrl_regs.sv */
// Control and identification register bank with its serial slave
`timescale 1ns/10ps
`include "cgsmb_params.svh"

// Summary of operation
// - Gate bit zero forces differential output low
// - Strap level readback, read only, bits 7:6
// - Override bit selects software spread amount
// - Software spread ignored while override clear
// - Two amplitude bits, reset to 0.8V code
// - Per-output edge rate, one means fast
// - Reference edge rate and reference enable
// - Wake-on-LAN keeps reference running in powerdown
// - Revision and vendor nibbles, read only
// - Device type and identifier, read only
// - Read length field, resets to eight
// - Block read: count first, then data bytes
// - Address select pin latched, not followed
module cgsmb_ctrl_regs #(
   parameter logic [6:0] SMB_ADDR_LO = 7'h50,
   parameter logic [6:0] SMB_ADDR_HI = 7'h52,
   parameter logic [3:0] REV_ID      = 4'h3,  // Arbitrary value
   parameter logic [3:0] VENDOR_ID   = 4'h5,  // Arbitrary value
   parameter logic [1:0] DEV_TYPE    = 2'h2,  // Arbitrary value
   parameter logic [5:0] DEV_ID      = 6'h15, // Arbitrary value
   parameter int         NUM_OUT     = 8
) (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_rst,
   // Serial bus
   input  wire logic               i_scl,
   input  wire logic               i_sda,
   output logic                    o_sda,
   output logic                    o_sda_oe,
   // Straps and pins
   input  wire logic               i_address_select_pin,
   input  wire logic [1:0]         i_spread_strap_lvl,
   input  wire logic               i_power_good_powerdown_pin,
   input  wire logic [NUM_OUT-1:0] i_output_gate_pin_n,
   // Clock path controls
   output logic [NUM_OUT-1:0]      o_diff_clock_output_run,
   output logic [NUM_OUT-1:0]      o_edge_rate_fast,
   output logic [1:0]              o_spread_amount,
   output logic [1:0]              o_amplitude,
   output logic [1:0]              o_ref_edge_rate,
   output logic                    o_ref_run
);
   import cgsmb_pkg::*;

   // ****************************************************************************
   // Straps
   // ****************************************************************************
   logic       strap_done_r, strap_done_nxt;
   logic       addr_sel_r, addr_sel_nxt;
   logic [1:0] strap_lvl_r, strap_lvl_nxt;

   // Captured once at first power good; later pin moves are ignored
   always_comb begin
      strap_done_nxt = strap_done_r;
      addr_sel_nxt   = addr_sel_r;
      strap_lvl_nxt  = strap_lvl_r;
      if (!strap_done_r && i_power_good_powerdown_pin) begin
         strap_done_nxt = 1'b1;
         addr_sel_nxt   = i_address_select_pin;
         strap_lvl_nxt  = i_spread_strap_lvl;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         strap_done_r <= 1'b0;
         addr_sel_r   <= 1'b0;
         strap_lvl_r  <= 2'h0;
      end else begin
         strap_done_r <= strap_done_nxt;
         addr_sel_r   <= addr_sel_nxt;
         strap_lvl_r  <= strap_lvl_nxt;
      end
   end

   // ****************************************************************************
   // Register bank
   // ****************************************************************************
   logic [7:0] gate_r, gate_nxt;
   logic       sw_ovr_r, sw_ovr_nxt;
   logic [1:0] sw_spread_r, sw_spread_nxt;
   logic [1:0] amp_r, amp_nxt;
   logic [7:0] edge_r, edge_nxt;
   logic [1:0] ref_edge_r, ref_edge_nxt;
   logic       wol_r, wol_nxt;
   logic       ref_oe_r, ref_oe_nxt;
   logic [4:0] rd_len_r, rd_len_nxt;
   logic       wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;

   // Read-only bytes and reserved bits take no write
   always_comb begin
      gate_nxt      = gate_r;
      sw_ovr_nxt    = sw_ovr_r;
      sw_spread_nxt = sw_spread_r;
      amp_nxt       = amp_r;
      edge_nxt      = edge_r;
      ref_edge_nxt  = ref_edge_r;
      wol_nxt       = wol_r;
      ref_oe_nxt    = ref_oe_r;
      rd_len_nxt    = rd_len_r;
      if (wr_en) begin
         case (wr_idx)
            `CGSMB_OFS_OUTPUT_GATE: gate_nxt = wr_data;
            `CGSMB_OFS_SPREAD_AMP: begin
               sw_ovr_nxt    = wr_data[5];
               sw_spread_nxt = wr_data[4:3];
               amp_nxt       = wr_data[1:0];
            end
            `CGSMB_OFS_EDGE_RATE: edge_nxt = wr_data;
            `CGSMB_OFS_REF_CTRL: begin
               ref_edge_nxt = wr_data[7:6];
               wol_nxt      = wr_data[5];
               ref_oe_nxt   = wr_data[4];
            end
            `CGSMB_OFS_READ_LENGTH: rd_len_nxt = wr_data[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         gate_r      <= `CGSMB_RST_OUTPUT_GATE;
         sw_ovr_r    <= `CGSMB_RST_SW_OVERRIDE;
         sw_spread_r <= `CGSMB_RST_SW_SPREAD;
         amp_r       <= `CGSMB_RST_AMPLITUDE;
         edge_r      <= `CGSMB_RST_EDGE_RATE;
         ref_edge_r  <= `CGSMB_RST_REF_EDGE;
         wol_r       <= `CGSMB_RST_WAKE_ON_LAN;
         ref_oe_r    <= `CGSMB_RST_REF_OE;
         rd_len_r    <= `CGSMB_RST_READ_LENGTH;
      end else begin
         gate_r      <= gate_nxt;
         sw_ovr_r    <= sw_ovr_nxt;
         sw_spread_r <= sw_spread_nxt;
         amp_r       <= amp_nxt;
         edge_r      <= edge_nxt;
         ref_edge_r  <= ref_edge_nxt;
         wol_r       <= wol_nxt;
         ref_oe_r    <= ref_oe_nxt;
         rd_len_r    <= rd_len_nxt;
      end
   end

   // Read view; unmapped indexes return zero
   function automatic logic [7:0] rd_byte(input logic [7:0] idx);
      logic [7:0] v;
      v = `CGSMB_RSVD_BYTE;
      case (idx)
         `CGSMB_OFS_OUTPUT_GATE: v = gate_r;
         `CGSMB_OFS_SPREAD_AMP:
            v = {strap_lvl_r, sw_ovr_r, sw_spread_r, `CGSMB_RSVD_SPREAD_B2, amp_r};
         `CGSMB_OFS_EDGE_RATE:   v = edge_r;
         `CGSMB_OFS_REF_CTRL:    v = {ref_edge_r, wol_r, ref_oe_r, `CGSMB_RSVD_REF_LOW};
         `CGSMB_OFS_REV_VENDOR:  v = {REV_ID, VENDOR_ID};
         `CGSMB_OFS_DEV_TYPE:    v = {DEV_TYPE, DEV_ID};
         `CGSMB_OFS_READ_LENGTH: v = {`CGSMB_RSVD_COUNT_HI, rd_len_r};
         default:                v = `CGSMB_RSVD_BYTE;
      endcase
      return v;
   endfunction

   // ****************************************************************************
   // Serial slave
   // ****************************************************************************
   cgsmb_state_t st_r, st_nxt;
   cgsmb_phase_t ph_r, ph_nxt;
   logic [7:0]   sh_r, sh_nxt;
   logic [3:0]   bit_r, bit_nxt;
   logic [7:0]   ptr_r, ptr_nxt;
   logic [7:0]   left_r, left_nxt;
   logic         ack_r, ack_nxt;
   logic         oe_r, oe_nxt;
   logic         scl_q, sda_q;
   logic         scl_rise, scl_fall, bus_start, bus_stop;
   logic [6:0]   dev_addr;
   logic [7:0]   tx_byte;
   logic [7:0]   cnt_byte;

   assign scl_rise  = i_scl & ~scl_q;
   assign scl_fall  = ~i_scl & scl_q;
   assign bus_start = i_scl & scl_q & sda_q & ~i_sda;
   assign bus_stop  = i_scl & scl_q & ~sda_q & i_sda;
   assign dev_addr  = addr_sel_r ? SMB_ADDR_HI : SMB_ADDR_LO;
   assign tx_byte   = rd_byte(ptr_r);
   assign cnt_byte  = {`CGSMB_RSVD_COUNT_HI, rd_len_r};
   assign wr_idx    = ptr_r;
   assign wr_data   = sh_r;

   always_comb begin
      st_nxt   = st_r;
      ph_nxt   = ph_r;
      sh_nxt   = sh_r;
      bit_nxt  = bit_r;
      ptr_nxt  = ptr_r;
      left_nxt = left_r;
      ack_nxt  = ack_r;
      oe_nxt   = oe_r;
      wr_en    = 1'b0;
      if (bus_start) begin
         st_nxt  = CGSMB_ST_RX;
         ph_nxt  = CGSMB_PH_ADDR;
         bit_nxt = 4'h0;
         oe_nxt  = 1'b0;
      end else if (bus_stop) begin
         st_nxt = CGSMB_ST_IDLE;
         oe_nxt = 1'b0;
      end else begin
         unique case (st_r)
            CGSMB_ST_IDLE: ;
            CGSMB_ST_RX: begin
               if (scl_rise) begin
                  sh_nxt  = {sh_r[6:0], i_sda};
                  bit_nxt = bit_r + 4'h1;
               end else if (scl_fall && bit_r == `CGSMB_BITS_PER_BYTE) begin
                  bit_nxt = 4'h0;
                  st_nxt  = CGSMB_ST_RXACK;
                  oe_nxt  = 1'b1;
                  case (ph_r)
                     CGSMB_PH_ADDR: begin
                        if (sh_r[7:1] != dev_addr) begin
                           st_nxt = CGSMB_ST_IDLE;
                           oe_nxt = 1'b0;
                        end else if (sh_r[0]) begin
                           ph_nxt = CGSMB_PH_READ;
                        end else begin
                           ph_nxt = CGSMB_PH_INDEX;
                        end
                     end
                     CGSMB_PH_INDEX: begin
                        ptr_nxt = sh_r;
                        ph_nxt  = CGSMB_PH_COUNT;
                     end
                     CGSMB_PH_COUNT: begin
                        left_nxt = sh_r;
                        ph_nxt   = CGSMB_PH_DATA;
                     end
                     CGSMB_PH_DATA: begin
                        // Bytes past the count are acked but dropped
                        if (left_r != 8'h00) begin
                           wr_en    = 1'b1;
                           ptr_nxt  = ptr_r + 8'h01;
                           left_nxt = left_r - 8'h01;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            CGSMB_ST_RXACK: begin
               if (scl_fall) begin
                  if (ph_r == CGSMB_PH_READ) begin
                     st_nxt = CGSMB_ST_TX;
                     sh_nxt = cnt_byte;
                     // First count bit must already stand before the host clocks it
                     oe_nxt = ~cnt_byte[7];
                  end else begin
                     st_nxt = CGSMB_ST_RX;
                     oe_nxt = 1'b0;
                  end
               end
            end
            CGSMB_ST_TX: begin
               if (scl_fall) begin
                  if (bit_r == `CGSMB_LAST_TX_BIT) begin
                     st_nxt  = CGSMB_ST_TXACK;
                     bit_nxt = 4'h0;
                     oe_nxt  = 1'b0;
                  end else begin
                     sh_nxt  = {sh_r[6:0], 1'b0};
                     bit_nxt = bit_r + 4'h1;
                     oe_nxt  = ~sh_r[6];
                  end
               end
            end
            CGSMB_ST_TXACK: begin
               if (scl_rise) begin
                  ack_nxt = ~i_sda;
               end else if (scl_fall) begin
                  // Host not-acknowledge ends the read
                  if (ack_r) begin
                     st_nxt  = CGSMB_ST_TX;
                     sh_nxt  = tx_byte;
                     oe_nxt  = ~tx_byte[7];
                     ptr_nxt = ptr_r + 8'h01;
                  end else begin
                     st_nxt = CGSMB_ST_IDLE;
                  end
               end
            end
            default: st_nxt = CGSMB_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r   <= CGSMB_ST_IDLE;
         ph_r   <= CGSMB_PH_ADDR;
         sh_r   <= 8'h00;
         bit_r  <= 4'h0;
         ptr_r  <= 8'h00;
         left_r <= 8'h00;
         ack_r  <= 1'b0;
         oe_r   <= 1'b0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         st_r   <= st_nxt;
         ph_r   <= ph_nxt;
         sh_r   <= sh_nxt;
         bit_r  <= bit_nxt;
         ptr_r  <= ptr_nxt;
         left_r <= left_nxt;
         ack_r  <= ack_nxt;
         oe_r   <= oe_nxt;
         scl_q  <= i_scl;
         sda_q  <= i_sda;
      end
   end

   // Open drain: only ever pulls low
   assign o_sda    = 1'b0;
   assign o_sda_oe = oe_r;

   // ****************************************************************************
   // Clock path controls
   // ****************************************************************************
   logic [NUM_OUT-1:0] run_nxt;
   logic [1:0]         spread_nxt;
   logic               ref_run_nxt;

   always_comb begin
      run_nxt     = gate_r[NUM_OUT-1:0] & ~i_output_gate_pin_n
                    & {NUM_OUT{i_power_good_powerdown_pin}};
      spread_nxt  = sw_ovr_r ? sw_spread_r : strap_lvl_r;
      ref_run_nxt = ref_oe_r & (i_power_good_powerdown_pin | wol_r);
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_diff_clock_output_run <= '0;
         o_edge_rate_fast        <= '1;
         o_spread_amount         <= 2'h0;
         o_amplitude             <= `CGSMB_RST_AMPLITUDE;
         o_ref_edge_rate         <= `CGSMB_RST_REF_EDGE;
         o_ref_run               <= 1'b0;
      end else begin
         o_diff_clock_output_run <= run_nxt;
         o_edge_rate_fast        <= edge_r[NUM_OUT-1:0];
         o_spread_amount         <= spread_nxt;
         o_amplitude             <= amp_r;
         o_ref_edge_rate         <= ref_edge_r;
         o_ref_run               <= ref_run_nxt;
      end
   end

endmodule

/* include/cgsmb_params.svh */
// Offsets, reset values, reserved read levels and bus constants of the clock generator control bank
`ifndef CGSMB_PARAMS_SVH
`define CGSMB_PARAMS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define CGSMB_OFS_OUTPUT_GATE    8'h00
`define CGSMB_OFS_SPREAD_AMP     8'h01
`define CGSMB_OFS_EDGE_RATE      8'h02
`define CGSMB_OFS_REF_CTRL       8'h03
`define CGSMB_OFS_RESERVED       8'h04
`define CGSMB_OFS_REV_VENDOR     8'h05
`define CGSMB_OFS_DEV_TYPE       8'h06
`define CGSMB_OFS_READ_LENGTH    8'h07

// ****************************************************************************
// Reset values
// ****************************************************************************
`define CGSMB_RST_OUTPUT_GATE    8'hff
`define CGSMB_RST_SW_OVERRIDE    1'b0
`define CGSMB_RST_SW_SPREAD      2'h0
`define CGSMB_RST_AMPLITUDE      2'h2
`define CGSMB_RST_EDGE_RATE      8'hff
`define CGSMB_RST_REF_EDGE       2'h1
`define CGSMB_RST_WAKE_ON_LAN    1'b0
`define CGSMB_RST_REF_OE         1'b1
`define CGSMB_RST_READ_LENGTH    5'h08

// ****************************************************************************
// Fixed read levels of reserved bits and the empty byte
// ****************************************************************************
`define CGSMB_RSVD_SPREAD_B2     1'b1
`define CGSMB_RSVD_REF_LOW       4'h9
`define CGSMB_RSVD_BYTE          8'h00
`define CGSMB_RSVD_COUNT_HI      3'h0

// ****************************************************************************
// Serial bus framing
// ****************************************************************************
`define CGSMB_BITS_PER_BYTE      4'h8
`define CGSMB_LAST_TX_BIT        4'h7

`endif

/* include/cgsmb_pkg.sv */
// Types shared by the clock generator control bank
package cgsmb_pkg;

   // Serial engine states, one-hot
   typedef enum logic [4:0] {
      CGSMB_ST_IDLE  = 5'b00001,
      CGSMB_ST_RX    = 5'b00010,
      CGSMB_ST_RXACK = 5'b00100,
      CGSMB_ST_TX    = 5'b01000,
      CGSMB_ST_TXACK = 5'b10000
   } cgsmb_state_t;

   // Meaning of the next received byte, one-hot
   typedef enum logic [4:0] {
      CGSMB_PH_ADDR  = 5'b00001,
      CGSMB_PH_INDEX = 5'b00010,
      CGSMB_PH_COUNT = 5'b00100,
      CGSMB_PH_DATA  = 5'b01000,
      CGSMB_PH_READ  = 5'b10000
   } cgsmb_phase_t;

endpackage

/* dv/cgsmb_regs_chk_sva.sv */
// Port assertions of the clock generator control bank
`timescale 1ns/10ps
module cgsmb_regs_chk #(
   parameter int NUM_OUT = 8
) (
   input wire logic               i_clock,
   input wire logic               i_rst,
   input wire logic               i_scl,
   input wire logic               o_sda,
   input wire logic               o_sda_oe,
   input wire logic               i_power_good_powerdown_pin,
   input wire logic [NUM_OUT-1:0] i_output_gate_pin_n,
   input wire logic [NUM_OUT-1:0] o_diff_clock_output_run,
   input wire logic [NUM_OUT-1:0] o_edge_rate_fast,
   input wire logic [1:0]         o_amplitude,
   input wire logic [1:0]         o_ref_edge_rate
);
   // ****
   // Properties
   // ****
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sda_const_a:
      assert property (o_sda == 1'b0) else $error("Open drain data value not zero");
   rst_vals_a:
      assert property ($fell(i_rst) |-> o_edge_rate_fast == 8'hff && o_amplitude == 2'h2
         && o_ref_edge_rate == 2'h1 && !o_sda_oe) else $error("Controls not at reset values");
   power_down_a:
      assert property (!i_power_good_powerdown_pin |=> o_diff_clock_output_run == '0)
      else $error("Output running in power down");
   pin_gate_a:
      assert property (1'b1 |=> (o_diff_clock_output_run & $past(i_output_gate_pin_n)) == '0)
      else $error("Output running with its enable pin high");
   ack_rise_a:
      assert property ($rose(o_sda_oe) |-> !i_scl) else $error("Data pulled while clock high");
   ack_fall_a:
      assert property ($fell(o_sda_oe) |-> !i_scl) else $error("Data freed while clock high");
   sda_hold_a:
      assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("Data moved during clock high");
   ctrl_quiet_a:
      assert property ($changed({o_edge_rate_fast, o_amplitude, o_ref_edge_rate}) |-> !i_scl)
      else $error("Control changed outside a bus low phase");
   cover property ($rose(o_sda_oe));
   cover property ($fell(i_power_good_powerdown_pin));
   cover property ($changed(o_edge_rate_fast));
endmodule
bind cgsmb_ctrl_regs cgsmb_regs_chk #(.NUM_OUT(NUM_OUT)) u_regs_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_power_good_powerdown_pin(i_power_good_powerdown_pin),
   .i_output_gate_pin_n(i_output_gate_pin_n),
   .o_diff_clock_output_run(o_diff_clock_output_run),
   .o_edge_rate_fast(o_edge_rate_fast), .o_amplitude(o_amplitude),
   .o_ref_edge_rate(o_ref_edge_rate));

/* dv/cgsmb_host_model.sv */
// SMBus host model issuing block writes and block reads
`timescale 1ns/10ps
module cgsmb_host_model (
   // Clock
   input  wire logic  i_clock,
   // Serial bus
   input  wire logic  i_sda,
   output logic       o_scl,
   output logic       o_sda_pull,
   // Results
   output logic       o_rd_valid,
   output logic [7:0] o_rd_byte,
   output logic [7:0] o_nack_cnt
);
   // ****
   // Bit timing
   // ****
   // Data moves mid low phase, clear of a synchronised clock edge
   localparam int HALF = 5;
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
      o_rd_valid = 1'b0;
      o_rd_byte = 8'h00;
      o_nack_cnt = 8'h00;
   end
   task automatic half();
      repeat (HALF) @(posedge i_clock);
      #1;
   endtask
   task automatic clk_bit(output logic s);
      half();
      o_scl = 1'b1;
      half();
      s = i_sda;
      o_scl = 1'b0;
      half();
   endtask
   task automatic put_bit(input logic b);
      logic s;
      o_sda_pull = ~b;
      clk_bit(s);
   endtask
   // Start and repeated start share one sequence
   task automatic start();
      o_sda_pull = 1'b0;
      half();
      o_scl = 1'b1;
      half();
      o_sda_pull = 1'b1;
      half();
      o_scl = 1'b0;
      half();
   endtask
   task automatic stop();
      o_sda_pull = 1'b1;
      half();
      o_scl = 1'b1;
      half();
      o_sda_pull = 1'b0;
      half();
   endtask
   // ****
   // Transfers
   // ****
   task automatic wr_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      o_sda_pull = 1'b0;
      clk_bit(s);
      if (s) o_nack_cnt = o_nack_cnt + 8'h01;
   endtask
   task automatic rd_byte(input logic last);
      logic       s;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         o_sda_pull = 1'b0;
         clk_bit(s);
         d = {d[6:0], s};
      end
      put_bit(last);
      o_rd_byte = d;
      o_rd_valid = 1'b1;
      @(posedge i_clock);
      #1 o_rd_valid = 1'b0;
   endtask
   task automatic block_write(input logic [6:0] a, input logic [7:0] idx,
                              input logic [7:0] cnt, input logic [7:0] d[]);
      start();
      wr_byte({a, 1'b0});
      wr_byte(idx);
      wr_byte(cnt);
      foreach (d[i]) wr_byte(d[i]);
      stop();
   endtask
   task automatic block_read(input logic [6:0] a, input logic [7:0] idx, input int n);
      start();
      wr_byte({a, 1'b0});
      wr_byte(idx);
      start();
      wr_byte({a, 1'b1});
      for (int i = 0; i < n; i++) rd_byte(i == n - 1);
      stop();
   endtask
endmodule

/* dv/cgsmb_tb.sv */
// Self-checking bench of the clock generator control bank
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tb;
   localparam logic [6:0] ADR_LO = 7'h50;
   localparam logic [6:0] ADR_HI = 7'h52;
   localparam logic [1:0] STRAP  = 2'b01;
   localparam logic [3:0] REV    = 4'ha;  // Arbitrary value
   localparam logic [3:0] VEN    = 4'h6;  // Arbitrary value
   localparam logic [1:0] DTYPE  = 2'h1;  // Arbitrary value
   localparam logic [5:0] DID    = 6'h2c; // Arbitrary value
   logic        clk, rst, scl, pull, adr_pin, pg, snap, rd_valid, sda_o, oe, ref_run;
   logic        sw_ov, wake_on_lan_keepalive, ren;
   logic [7:0]  pins, rd_byte, nack_cnt, gate, erate, enack, gv, ev, run, fast;
   logic [1:0]  sw, amp, redge, spread, amp_o, redge_o, strap;
   logic [4:0]  rlen;
   logic [30:0] exp_q[$];
   logic [30:0] obs, expv;
   int          bad_count, checks;
   integer      seed;
   wire         sda = ~(oe | pull);
   cgsmb_ctrl_regs #(.REV_ID(REV), .VENDOR_ID(VEN), .DEV_TYPE(DTYPE), .DEV_ID(DID)) dut (
      .i_clock(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(oe),
      .i_address_select_pin(adr_pin), .i_spread_strap_lvl(strap),
      .i_power_good_powerdown_pin(pg), .i_output_gate_pin_n(pins),
      .o_diff_clock_output_run(run), .o_edge_rate_fast(fast), .o_spread_amount(spread),
      .o_amplitude(amp_o), .o_ref_edge_rate(redge_o), .o_ref_run(ref_run));
   cgsmb_host_model host (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull),
      .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_nack_cnt(nack_cnt));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ****
   // Reference model
   // ****
   task automatic apply(input logic [7:0] i, input logic [7:0] v);
      case (i)
         8'h00: gate = v;
         8'h01: {sw_ov, sw, amp} = {v[5:3], v[1:0]};
         8'h02: erate = v;
         8'h03: {redge, wake_on_lan_keepalive, ren} = v[7:4];
         8'h07: rlen = v[4:0];
         default: ;
      endcase
   endtask
   function automatic logic [7:0] reg_at(input logic [7:0] i);
      case (i)
         8'h00: return gate;
         8'h01: return {strap, sw_ov, sw, 1'b1, amp};
         8'h02: return erate;
         8'h03: return {redge, wake_on_lan_keepalive, ren, 4'h9};
         8'h05: return {REV, VEN};
         8'h06: return {DTYPE, DID};
         8'h07: return {3'h0, rlen};
         default: return 8'h00;
      endcase
   endfunction
   task automatic model_reset();
      apply(8'h00, 8'hff);
      apply(8'h01, 8'h02);
      apply(8'h02, 8'hff);
      apply(8'h03, 8'h50);
      apply(8'h07, 8'h08);
   endtask
   task automatic reg_wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] cnt,
                         input logic [7:0] d[]);
      for (int k = 0; k < d.size(); k++) begin
         if (a != ADR_LO) enack = enack + 8'h01;
         else if (k < cnt) apply(idx + 8'(k), d[k]);
      end
      if (a != ADR_LO) enack = enack + 8'h03;
      host.block_write(a, idx, cnt, d);
   endtask
   task automatic reg_rd(input logic [7:0] idx, input int n);
      exp_q.push_back({26'h0, rlen});
      for (int k = 0; k < n; k++) exp_q.push_back({23'h0, reg_at(idx + 8'(k))});
      host.block_read(ADR_LO, idx, n + 1);
   endtask
   task automatic check_ports();
      repeat (3) @(posedge clk);
      #1 exp_q.push_back({enack, gate & ~pins & {8{pg}}, erate, sw_ov ? sw : strap, amp,
                          redge, ren & (pg | wake_on_lan_keepalive)});
      snap = 1'b1;
      @(posedge clk);
      #1 snap = 1'b0;
   endtask
   // ****
   // Result watcher and verdict
   // ****
   always @(posedge clk) begin
      if (rd_valid || snap) begin
         obs = snap ? {nack_cnt, run, fast, spread, amp_o, redge_o, ref_run} : {23'h0, rd_byte};
         expv = (exp_q.size() > 0) ? exp_q.pop_front() : ~obs;
         `CHK(obs, expv)
      end
   end
   task automatic tally_and_finish();
      if (exp_q.size() != 0) bad_count++;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      seed = 32'he99d54d1;
      rst = 1'b1;
      pins = 8'h00;
      pg = 1'b1;
      adr_pin = 1'b0;
      snap = 1'b0;
      enack = 8'h00;
      strap = STRAP;
      model_reset();
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      check_ports();
      reg_rd(8'h00, 8);
      $display("test defaults done");
      gv = 8'($random(seed));
      ev = 8'($random(seed));
      reg_wr(ADR_LO, 8'h00, 8'h03, '{gv, 8'hff, ev, 8'h0f});
      reg_wr(ADR_LO, 8'h03, 8'h05, '{8'h2f, 8'haa, 8'hbb, 8'hcc, 8'he4});
      reg_rd(8'h00, 4);
      check_ports();
      $display("test block write done");
      for (int c = 0; c < 8; c++) begin
         reg_wr(ADR_LO, 8'h01, 8'h01, '{{2'b11, c[0], c[2:1], 1'b0, c[2:1]}});
         check_ports();
      end
      reg_rd(8'h01, 1);
      $display("test spread done");
      pins = 8'($random(seed));
      check_ports();
      reg_wr(ADR_LO, 8'h03, 8'h01, '{8'h90});
      pg = 1'b0;
      check_ports();
      reg_wr(ADR_LO, 8'h03, 8'h01, '{8'hf0});
      check_ports();
      pg = 1'b1;
      $display("test power done");
      adr_pin = 1'b1;
      reg_wr(ADR_HI, 8'h00, 8'h01, '{8'h00});
      check_ports();
      reg_rd(8'h07, 2);
      $display("test address done");
      // Second reset recaptures the straps at new levels
      rst = 1'b1;
      strap = 2'b11;
      adr_pin = 1'b0;
      model_reset();
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      check_ports();
      reg_rd(8'h01, 1);
      $display("test strap done");
      tally_and_finish();
   end
endmodule
